// ===== rtl/mcc_mac_control.sv
// Behaviour
// - Nine 16-bit indirect registers at 0x00-0x05 and station address 0x10-0x12.
// - Writing one to control bit 14 reseeds the backoff random generator.
// - Loopback bit routes transmit data back as receive data internally.
// - Full duplex: transmit flow bit clear blocks PAUSE frames, set passes them.
// - Full duplex: receive flow bit set acts on received PAUSE, clear ignores.
// - Receive enable clear blocks received packets from the next frame start; set delivers them.
// - Abort disable clear aborts on excess deferral; set retries indefinitely.
// - Half duplex: back pressure collision uses backoff unless bit 13 set.
// - Half duplex: collision uses backoff unless bit 12 set.
// - Long preamble reject discards preambles above 12 bytes.
// - Preamble enforcement checks for error-free 0x55 bytes.
// - Pad mode is ignored while pad enable is zero.
// - CRC append set adds CRC; clear means frames already carry one.
// - Padding pads short frames to 60 bytes, or 64 with low mode bit.
// - Header bit excludes first four bytes from the CRC.
// - Length check compares frame length with the Length/Type field.
// - Duplex bit: zero half duplex, one full duplex.
// - Address, data bytes, initiate write commits; initiate read fetches.
`timescale 1ns/1ns
`default_nettype none

module mcc_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  // Fill side
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  // Drain side
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    empty;
  } mcc_fifo_t;

  mcc_fifo_t r_reg;
  mcc_fifo_t r_next;
  logic      push;
  logic      pop;

  // Flags kept as flops so both ready and valid are glitch free
  always_comb begin
    r_next = r_reg;
    push   = in_valid_in && !r_reg.full;
    pop    = out_ready_in && !r_reg.empty;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data_in;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    r_next.full  = (r_next.cnt == (AW+1)'(DEPTH));
    r_next.empty = (r_next.cnt == '0);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg       <= '0;
      r_reg.empty <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready_out  = !r_reg.full;
  assign out_valid_out = !r_reg.empty;
  assign out_data_out  = r_reg.mem[r_reg.rp];
endmodule : mcc_fifo

module mcc_mac_control #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Host register window
  input  wire logic [7:0]       host_addr_in,
  input  wire logic [7:0]       host_wdata_in,
  input  wire logic             host_wr_in,
  input  wire logic             host_rd_in,
  output logic [7:0]            host_rdata_out,
  output logic                  host_rvalid_out,
  // Transmit stream from host buffer
  input  wire mcc_pkg::mcc_beat_t tx_beat_in,
  input  wire logic             tx_valid_in,
  output logic                  tx_ready_out,
  // Transmit stream to physical layer
  output mcc_pkg::mcc_beat_t    phy_tx_beat_out,
  output logic                  phy_tx_valid_out,
  input  wire logic             phy_tx_ready_in,
  // Receive stream from physical layer
  input  wire mcc_pkg::mcc_beat_t phy_rx_beat_in,
  input  wire logic             phy_rx_valid_in,
  // Receive stream to host buffer
  output mcc_pkg::mcc_beat_t    rx_beat_out,
  output logic                  rx_valid_out,
  input  wire logic             rx_ready_in,
  // Settings and events for the frame engines
  output logic                  pause_act_out,
  output mcc_pkg::mcc_policy_t  policy_out,
  output mcc_pkg::mcc_timing_t  timing_out,
  output logic [47:0]           station_addr_out,
  output logic [15:0]           backoff_random_out
);
  typedef struct packed {
    logic [15:0]          ctl;
    logic [15:0]          cfg;
    mcc_pkg::mcc_timing_t tim;
    logic [15:0]          ad0;
    logic [15:0]          ad1;
    logic [15:0]          ad2;
    logic [7:0]           iaddr;
    logic [7:0]           dh;
    logic [7:0]           dl;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic [15:0]          rng;
    mcc_pkg::mcc_beat_t   txb;
    logic                 txv;
    mcc_pkg::mcc_beat_t   rxb;
    logic                 rxv;
    logic                 rx_in_frame;
    logic                 rx_drop;
    logic                 pause_act;
    mcc_pkg::mcc_policy_t pol;
  } mcc_state_t;

  mcc_state_t         r_reg;
  mcc_state_t         r_next;
  mcc_pkg::mcc_beat_t f_beat;
  logic               f_valid;
  logic               f_ready;
  logic               f_block;
  logic [15:0]        ird;
  logic [15:0]        wval;
  logic               fdx;
  logic               loop;
  logic               tx_slot;
  logic               rx_slot;
  logic               rx_sof;
  logic               rx_drop_now;

  mcc_fifo #(
    .W     ($bits(mcc_pkg::mcc_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_data_in    (tx_beat_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (f_beat),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready)
  );

  always_comb begin
    r_next         = r_reg;
    r_next.rvalid  = 1'b0;
    r_next.pause_act = 1'b0;
    fdx            = r_reg.cfg[mcc_pkg::CFG_FDX];
    loop           = r_reg.ctl[mcc_pkg::CTL_LOOP];
    wval           = {r_reg.dh, r_reg.dl};
    // Indirect read mux, unmapped indices read zero
    unique case (r_reg.iaddr)
      mcc_pkg::IDX_CTL:    ird = r_reg.ctl & mcc_pkg::CTL_RMASK;
      mcc_pkg::IDX_CFG:    ird = r_reg.cfg & mcc_pkg::CFG_RMASK;
      mcc_pkg::IDX_B2B:    ird = r_reg.tim.b2b_gap;
      mcc_pkg::IDX_NB2B:   ird = r_reg.tim.nb2b_gap;
      mcc_pkg::IDX_RETRY:  ird = r_reg.tim.retry;
      mcc_pkg::IDX_FRMLEN: ird = r_reg.tim.max_len;
      mcc_pkg::IDX_AD0:    ird = r_reg.ad0;
      mcc_pkg::IDX_AD1:    ird = r_reg.ad1;
      mcc_pkg::IDX_AD2:    ird = r_reg.ad2;
      default:             ird = 16'h0000;
    endcase
    // Generator free runs so backoff slots differ between stations
    if (r_reg.rng[0]) begin
      r_next.rng = (r_reg.rng >> 1) ^ mcc_pkg::RNG_TAPS;
    end else begin
      r_next.rng = r_reg.rng >> 1;
    end
    if (host_wr_in) begin
      unique case (host_addr_in)
        mcc_pkg::HOST_IADDR: r_next.iaddr = host_wdata_in;
        mcc_pkg::HOST_DHIGH: r_next.dh = host_wdata_in;
        mcc_pkg::HOST_DLOW:  r_next.dl = host_wdata_in;
        mcc_pkg::HOST_INIT: begin
          unique case (r_reg.iaddr)
            mcc_pkg::IDX_CTL: begin
              r_next.ctl = wval;
              if (wval[mcc_pkg::CTL_RNG]) begin
                r_next.rng = mcc_pkg::RNG_SEED;
              end
            end
            mcc_pkg::IDX_CFG:    r_next.cfg = wval;
            mcc_pkg::IDX_B2B:    r_next.tim.b2b_gap = wval;
            mcc_pkg::IDX_NB2B:   r_next.tim.nb2b_gap = wval;
            mcc_pkg::IDX_RETRY:  r_next.tim.retry = wval;
            mcc_pkg::IDX_FRMLEN: r_next.tim.max_len = wval;
            mcc_pkg::IDX_AD0:    r_next.ad0 = wval;
            mcc_pkg::IDX_AD1:    r_next.ad1 = wval;
            mcc_pkg::IDX_AD2:    r_next.ad2 = wval;
            default:             r_next.ad2 = r_reg.ad2;
          endcase
        end
        default: r_next.iaddr = r_reg.iaddr;
      endcase
    end
    if (host_rd_in) begin
      r_next.rvalid = 1'b1;
      unique case (host_addr_in)
        mcc_pkg::HOST_IADDR: r_next.rdata = r_reg.iaddr;
        mcc_pkg::HOST_DHIGH: r_next.rdata = r_reg.dh;
        mcc_pkg::HOST_DLOW:  r_next.rdata = r_reg.dl;
        mcc_pkg::HOST_INIT: begin
          {r_next.dh, r_next.dl} = ird;
          r_next.rdata = 8'h00;
        end
        default: r_next.rdata = 8'h00;
      endcase
    end
    // Policy for the frame engines, one cycle behind the registers
    r_next.pol.full_duplex    = fdx;
    r_next.pol.abort_on_defer = !r_reg.cfg[mcc_pkg::CFG_NOABRT];
    r_next.pol.bp_backoff     = !fdx && !r_reg.cfg[mcc_pkg::CFG_BPBOD];
    r_next.pol.col_backoff    = !fdx && !r_reg.cfg[mcc_pkg::CFG_COLBOD];
    r_next.pol.pre_limit      = r_reg.cfg[mcc_pkg::CFG_LPRE] ? mcc_pkg::PRE_LIMIT : 4'h0;
    r_next.pol.pure_pre       = r_reg.cfg[mcc_pkg::CFG_PPRE];
    r_next.pol.crc_append     = r_reg.cfg[mcc_pkg::CFG_CRC];
    r_next.pol.hdr_skip       = r_reg.cfg[mcc_pkg::CFG_HDR] ? mcc_pkg::HDR_BYTES : 3'h0;
    r_next.pol.len_check      = r_reg.cfg[mcc_pkg::CFG_LENCMP];
    // Pad mode only counts with pad and CRC both on
    if (!r_reg.cfg[mcc_pkg::CFG_PADON] || !r_reg.cfg[mcc_pkg::CFG_CRC]) begin
      r_next.pol.pad_len = 7'h00;
    end else if (r_reg.cfg[mcc_pkg::CFG_PADLO]) begin
      r_next.pol.pad_len = mcc_pkg::PAD_LONG;
    end else begin
      r_next.pol.pad_len = mcc_pkg::PAD_SHORT;
    end
    // Output handshakes
    tx_slot = !r_reg.txv || phy_tx_ready_in;
    rx_slot = !r_reg.rxv || rx_ready_in;
    if (r_reg.txv && phy_tx_ready_in) begin
      r_next.txv = 1'b0;
    end
    if (r_reg.rxv && rx_ready_in) begin
      r_next.rxv = 1'b0;
    end
    // Blocked beats are drained and dropped so the buffer never wedges
    f_block = f_beat.pause && fdx && !r_reg.ctl[mcc_pkg::CTL_TXFC];
    if (loop) begin
      f_ready = f_block || !r_reg.ctl[mcc_pkg::CTL_RXEN] || rx_slot;
    end else begin
      f_ready = f_block || tx_slot;
    end
    if (f_valid && !f_block) begin
      if (loop && r_reg.ctl[mcc_pkg::CTL_RXEN] && rx_slot) begin
        r_next.rxb = f_beat;
        r_next.rxv = 1'b1;
      end else if (!loop && tx_slot) begin
        r_next.txb = f_beat;
        r_next.txv = 1'b1;
      end
    end
    // Receive gate decided per frame at its first beat
    rx_sof      = !r_reg.rx_in_frame;
    rx_drop_now = rx_sof ? !r_reg.ctl[mcc_pkg::CTL_RXEN] : r_reg.rx_drop;
    if (phy_rx_valid_in && !loop) begin
      r_next.rx_drop     = rx_drop_now;
      r_next.rx_in_frame = !phy_rx_beat_in.last;
      // No stall toward the line: a beat meeting a full slot is lost
      if (!rx_drop_now && rx_slot) begin
        r_next.rxb = phy_rx_beat_in;
        r_next.rxv = 1'b1;
      end
      if (phy_rx_beat_in.pause && phy_rx_beat_in.last) begin
        r_next.pause_act = fdx && r_reg.ctl[mcc_pkg::CTL_RXFC];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg             <= '0;
      r_reg.ctl         <= mcc_pkg::CTL_RST;
      r_reg.cfg         <= mcc_pkg::CFG_RST;
      r_reg.tim.retry   <= mcc_pkg::RETRY_RST;
      r_reg.tim.max_len <= mcc_pkg::FRMLEN_RST;
      r_reg.rng         <= mcc_pkg::RNG_SEED;
      r_reg.pol.abort_on_defer <= 1'b1;
      r_reg.pol.bp_backoff     <= 1'b1;
      r_reg.pol.col_backoff    <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign host_rdata_out     = r_reg.rdata;
  assign host_rvalid_out    = r_reg.rvalid;
  assign phy_tx_beat_out    = r_reg.txb;
  assign phy_tx_valid_out   = r_reg.txv;
  assign rx_beat_out        = r_reg.rxb;
  assign rx_valid_out       = r_reg.rxv;
  assign pause_act_out      = r_reg.pause_act;
  assign policy_out         = r_reg.pol;
  assign timing_out         = r_reg.tim;
  assign station_addr_out   = {r_reg.ad2, r_reg.ad1, r_reg.ad0};
  assign backoff_random_out = r_reg.rng;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  logic init_wr;
  logic init_rd;
  assign init_wr = host_wr_in && host_addr_in == mcc_pkg::HOST_INIT;
  assign init_rd = host_rd_in && host_addr_in == mcc_pkg::HOST_INIT && !host_wr_in;

  a_cfg_commit: assert property (init_wr && r_reg.iaddr == mcc_pkg::IDX_CFG
    |=> r_reg.cfg == $past(wval)) else $error("config commit lost");
  a_init_fetch: assert property (init_rd && r_reg.iaddr == mcc_pkg::IDX_RETRY
    |=> {r_reg.dh, r_reg.dl} == $past(r_reg.tim.retry)) else $error("indirect fetch wrong");
  a_rng_reseed: assert property (init_wr && r_reg.iaddr == mcc_pkg::IDX_CTL && wval[14]
    |=> r_reg.rng == mcc_pkg::RNG_SEED) else $error("generator not reseeded");
  a_loop_route: assert property (loop && r_reg.ctl[0] && f_valid && !f_block && rx_slot
    |=> rx_valid_out && rx_beat_out == $past(f_beat)) else $error("loopback beat missing");
  a_pause_block: assert property (f_valid && f_beat.pause && fdx && !r_reg.ctl[3]
    |-> f_ready ##1 $stable(phy_tx_beat_out) || !phy_tx_valid_out) else $error("pause not blocked");
  a_pause_act: assert property (pause_act_out
    |-> $past(fdx && r_reg.ctl[2] && phy_rx_valid_in && phy_rx_beat_in.pause)) else $error("bad pause act");
  a_half_flow: assert property (!fdx ##1 !fdx |-> !pause_act_out) else $error("flow in half duplex");
  a_rx_gate: assert property (phy_rx_valid_in && !loop && rx_sof && !r_reg.ctl[0] && !rx_valid_out
    |=> !rx_valid_out) else $error("blocked frame delivered");
  a_pad_len: assert property (##1 policy_out.pad_len != 7'h00
    |-> $past(r_reg.cfg[5] && r_reg.cfg[4])) else $error("pad without enable");
  a_duplex_pol: assert property (##1 policy_out.full_duplex == $past(fdx)
    && (policy_out.col_backoff -> !$past(fdx))) else $error("duplex policy wrong");

  c_loopback: cover property (loop ##1 rx_valid_out);
  c_pause_act: cover property (pause_act_out);
  c_fifo_full: cover property (!tx_ready_out);
  c_cfg_write: cover property (init_wr ##[1:8] init_rd);
endmodule : mcc_mac_control

`default_nettype wire

// ===== rtl/mcc_pkg.sv
package mcc_pkg;
  // Host window addresses
  localparam logic [7:0] HOST_IADDR = 8'h0a;
  localparam logic [7:0] HOST_DHIGH = 8'h0b;
  localparam logic [7:0] HOST_DLOW  = 8'h0c;
  localparam logic [7:0] HOST_INIT  = 8'h0d;
  // Indirect register indices
  localparam logic [7:0] IDX_CTL    = 8'h00;
  localparam logic [7:0] IDX_CFG    = 8'h01;
  localparam logic [7:0] IDX_B2B    = 8'h02;
  localparam logic [7:0] IDX_NB2B   = 8'h03;
  localparam logic [7:0] IDX_RETRY  = 8'h04;
  localparam logic [7:0] IDX_FRMLEN = 8'h05;
  localparam logic [7:0] IDX_AD0    = 8'h10;
  localparam logic [7:0] IDX_AD1    = 8'h11;
  localparam logic [7:0] IDX_AD2    = 8'h12;
  // Reset values
  localparam logic [15:0] CTL_RST    = 16'h8000;
  localparam logic [15:0] CFG_RST    = 16'h0000;
  localparam logic [15:0] RETRY_RST  = 16'h370f;
  localparam logic [15:0] FRMLEN_RST = 16'h0600;
  // Read masks, reserved bits read as zero
  localparam logic [15:0] CTL_RMASK  = 16'hfffd;
  localparam logic [15:0] CFG_RMASK  = 16'h73fb;
  // Control bit positions
  localparam int CTL_RNG  = 14;
  localparam int CTL_LOOP = 4;
  localparam int CTL_TXFC = 3;
  localparam int CTL_RXFC = 2;
  localparam int CTL_RXEN = 0;
  // Configuration bit positions
  localparam int CFG_NOABRT = 14;
  localparam int CFG_BPBOD  = 13;
  localparam int CFG_COLBOD = 12;
  localparam int CFG_LPRE   = 9;
  localparam int CFG_PPRE   = 8;
  localparam int CFG_PADLO  = 6;
  localparam int CFG_PADON  = 5;
  localparam int CFG_CRC    = 4;
  localparam int CFG_HDR    = 3;
  localparam int CFG_LENCMP = 1;
  localparam int CFG_FDX    = 0;
  // Frame figures
  localparam logic [6:0] PAD_SHORT = 7'h3c;
  localparam logic [6:0] PAD_LONG  = 7'h40;
  localparam logic [3:0] PRE_LIMIT = 4'hc;
  localparam logic [2:0] HDR_BYTES = 3'h4;
  // Backoff generator, seed arbitrary nonzero
  localparam logic [15:0] RNG_SEED = 16'hace1;
  localparam logic [15:0] RNG_TAPS = 16'hb400;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       pause;
  } mcc_beat_t;

  typedef struct packed {
    logic       full_duplex;
    logic       abort_on_defer;
    logic       bp_backoff;
    logic       col_backoff;
    logic [3:0] pre_limit;
    logic       pure_pre;
    logic       crc_append;
    logic [6:0] pad_len;
    logic [2:0] hdr_skip;
    logic       len_check;
  } mcc_policy_t;

  typedef struct packed {
    logic [15:0] b2b_gap;
    logic [15:0] nb2b_gap;
    logic [15:0] retry;
    logic [15:0] max_len;
  } mcc_timing_t;
endpackage : mcc_pkg

// ===== tb/mcc_phy_model.sv
`timescale 1ns/1ns
`default_nettype none

module mcc_phy_model (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  // Transmit side from the MAC
  input  wire mcc_pkg::mcc_beat_t phy_tx_beat_in,
  input  wire logic               phy_tx_valid_in,
  output logic                    phy_tx_ready_out,
  // Receive side towards the MAC
  output mcc_pkg::mcc_beat_t      phy_rx_beat_out,
  output logic                    phy_rx_valid_out,
  // Pace: 0 prompt, 1 slow, 2 stopped
  input  wire logic [1:0]         mode_in
);
  logic [1:0]         tick = 2'h0;
  mcc_pkg::mcc_beat_t tx_q[$];

  initial begin
    phy_tx_ready_out = 1'b0;
    phy_rx_valid_out = 1'b0;
    phy_rx_beat_out  = '0;
  end

  // Slow pace takes one beat in four so the FIFO backs up
  always @(negedge clk_in) begin
    tick <= tick + 2'h1;
    phy_tx_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && tick == 2'h0);
  end

  always @(posedge clk_in) begin
    if (reset_n_in && phy_tx_valid_in && phy_tx_ready_out) begin
      tx_q.push_back(phy_tx_beat_in);
    end
  end

  task automatic send_frame(input logic [7:0] base, input int n, input logic pause);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      phy_rx_valid_out = 1'b1;
      phy_rx_beat_out  = '{data: base + 8'(i), last: (i == n - 1), pause: pause};
    end
    @(negedge clk_in);
    phy_rx_valid_out = 1'b0;
    // Idle line must not look like a stale beat
    phy_rx_beat_out  = ~phy_rx_beat_out;
  endtask : send_frame
endmodule : mcc_phy_model

`default_nettype wire

// ===== tb/test_mac_control_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

module test_mac_control_config_regs;
  logic                 clk = 1'b0;
  logic                 rst_n, wr, rd, tx_valid, rx_ready, rvalid, tx_ready;
  logic                 ptx_valid, ptx_ready, prx_valid, rx_valid, pause_act;
  logic [7:0]           addr, wdata, rdata;
  logic [1:0]           mode;
  logic [15:0]          rnd;
  logic [47:0]          station;
  mcc_pkg::mcc_beat_t   tx_beat, ptx_beat, prx_beat, rx_beat;
  mcc_pkg::mcc_policy_t policy;
  mcc_pkg::mcc_timing_t timing;
  mcc_pkg::mcc_beat_t   rx_q[$], exp_q[$];
  int                   num_errors = 0;
  int                   n_checks = 0;
  int                   pause_cnt = 0;

  always #5 clk = ~clk;

  mcc_mac_control #(.FIFO_DEPTH(8)) dut (
    .clk_in(clk), .reset_n_in(rst_n), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_wr_in(wr), .host_rd_in(rd), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
    .tx_beat_in(tx_beat), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .phy_tx_beat_out(ptx_beat), .phy_tx_valid_out(ptx_valid), .phy_tx_ready_in(ptx_ready),
    .phy_rx_beat_in(prx_beat), .phy_rx_valid_in(prx_valid), .rx_beat_out(rx_beat),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .pause_act_out(pause_act),
    .policy_out(policy), .timing_out(timing), .station_addr_out(station), .backoff_random_out(rnd));

  mcc_phy_model phy (
    .clk_in(clk), .reset_n_in(rst_n), .phy_tx_beat_in(ptx_beat), .phy_tx_valid_in(ptx_valid),
    .phy_tx_ready_out(ptx_ready), .phy_rx_beat_out(prx_beat), .phy_rx_valid_out(prx_valid), .mode_in(mode));

  always @(posedge clk) begin
    if (rx_valid && rx_ready) rx_q.push_back(rx_beat);
    if (pause_act) pause_cnt++;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_q(input mcc_pkg::mcc_beat_t got[$], input mcc_pkg::mcc_beat_t exp[$]);
    check_val(got.size(), exp.size());
    for (int i = 0; i < got.size() && i < exp.size(); i++) check_val(got[i], exp[i]);
  endtask : check_q

  function automatic mcc_pkg::mcc_beat_t mk(input logic [7:0] b, input int i, input int n, input logic p);
    return '{data: b + 8'(i), last: (i == n - 1), pause: p};
  endfunction : mk

  function automatic mcc_pkg::mcc_policy_t exp_policy(input logic [15:0] c);
    mcc_pkg::mcc_policy_t p;
    p.full_duplex    = c[0];
    p.abort_on_defer = !c[14];
    p.bp_backoff     = !c[13] && !c[0];
    p.col_backoff    = !c[12] && !c[0];
    p.pre_limit      = c[9] ? 4'hc : 4'h0;
    p.pure_pre       = c[8];
    p.crc_append     = c[4];
    p.pad_len        = !(c[5] && c[4]) ? 7'h00 : c[6] ? 7'h40 : 7'h3c;
    p.hdr_skip       = c[3] ? 3'h4 : 3'h0;
    p.len_check      = c[1];
    return p;
  endfunction : exp_policy

  function automatic logic [15:0] pat(input int i);
    return 16'ha5c0 + 16'(i) * 16'h0101;
  endfunction : pat

  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
  endtask : host_wr

  task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd   = 1'b1;
    @(negedge clk);
    rd   = 1'b0;
    check_val(rvalid, 1'b1);
    d    = rdata;
  endtask : host_rd

  task automatic ind_write(input logic [7:0] idx, input logic [15:0] v);
    host_wr(mcc_pkg::HOST_IADDR, idx);
    host_wr(mcc_pkg::HOST_DHIGH, v[15:8]);
    host_wr(mcc_pkg::HOST_DLOW, v[7:0]);
    host_wr(mcc_pkg::HOST_INIT, 8'h00);
  endtask : ind_write

  task automatic ind_read(input logic [7:0] idx, output logic [15:0] v);
    logic [7:0] d;
    host_wr(mcc_pkg::HOST_IADDR, idx);
    host_rd(mcc_pkg::HOST_INIT, d);
    host_rd(mcc_pkg::HOST_DHIGH, v[15:8]);
    host_rd(mcc_pkg::HOST_DLOW, v[7:0]);
  endtask : ind_read

  task automatic send_tx(input logic [7:0] b, input int n, input logic p, input logic keep);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      tx_beat  = mk(b, i, n, p);
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) @(negedge clk);
      if (keep) exp_q.push_back(tx_beat);
    end
    @(negedge clk);
    tx_valid = 1'b0;
    tx_beat  = ~tx_beat;
  endtask : send_tx

  task automatic setup(input logic [15:0] cfg, input logic [15:0] ctl);
    ind_write(mcc_pkg::IDX_CFG, cfg);
    ind_write(mcc_pkg::IDX_CTL, ctl);
    repeat (40) @(negedge clk);
    rx_q.delete();
    exp_q.delete();
    phy.tx_q.delete();
  endtask : setup

  task automatic t_regs;
    logic [7:0]  idx [7];
    logic [7:0]  d;
    logic [15:0] v;
    idx = '{mcc_pkg::IDX_B2B, mcc_pkg::IDX_NB2B, mcc_pkg::IDX_RETRY, mcc_pkg::IDX_FRMLEN,
            mcc_pkg::IDX_AD0, mcc_pkg::IDX_AD1, mcc_pkg::IDX_AD2};
    ind_read(mcc_pkg::IDX_CTL, v);
    check_val(v, 16'h8000);
    ind_read(mcc_pkg::IDX_CFG, v);
    check_val(v, 16'h0000);
    check_val(policy, exp_policy(16'h0000));
    check_val(timing, {32'h0, 16'h370f, 16'h0600});
    for (int i = 0; i < 7; i++) ind_write(idx[i], pat(i));
    for (int i = 0; i < 7; i++) begin
      ind_read(idx[i], v);
      check_val(v, pat(i));
    end
    check_val(station, {pat(6), pat(5), pat(4)});
    check_val(timing, {pat(0), pat(1), pat(2), pat(3)});
    ind_write(8'h06, 16'hbeef);
    ind_read(8'h06, v);
    check_val(v, 16'h0000);
    host_rd(8'h0e, d);
    check_val(d, 8'h00);
    ind_write(mcc_pkg::IDX_CTL, 16'h001d);
    ind_read(mcc_pkg::IDX_CTL, v);
    check_val(v, 16'h001d & mcc_pkg::CTL_RMASK);
  endtask : t_regs

  task automatic t_policy;
    logic [15:0] cfgs [8];
    logic [15:0] v;
    // Pad only with pad enable and CRC both on
    cfgs = '{16'h40b3, 16'h4012, 16'h3300, 16'h0079, 16'h0031, 16'h00d0, 16'h3001, 16'h020a};
    for (int i = 0; i < 8; i++) begin
      ind_write(mcc_pkg::IDX_CFG, cfgs[i]);
      repeat (2) @(negedge clk);
      check_val(policy, exp_policy(cfgs[i]));
      ind_read(mcc_pkg::IDX_CFG, v);
      check_val(v, cfgs[i] & mcc_pkg::CFG_RMASK);
    end
  endtask : t_policy

  task automatic t_rng;
    logic hit;
    hit = 1'b0;
    repeat (5) @(negedge clk);
    ind_write(mcc_pkg::IDX_CTL, 16'h4000);
    for (int k = 0; k < 6; k++) begin
      if (rnd === mcc_pkg::RNG_SEED) hit = 1'b1;
      @(negedge clk);
    end
    check_val(hit, 1'b1);
  endtask : t_rng

  task automatic t_tx;
    setup(16'h0001, 16'h0001);
    mode = 2'h1;
    send_tx(8'h10, 3, 1'b0, 1'b1);
    send_tx(8'h20, 2, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    ind_write(mcc_pkg::IDX_CTL, 16'h0009);
    send_tx(8'h30, 2, 1'b1, 1'b1);
    repeat (40) @(negedge clk);
    ind_write(mcc_pkg::IDX_CFG, 16'h0000);
    ind_write(mcc_pkg::IDX_CTL, 16'h0001);
    send_tx(8'h40, 2, 1'b1, 1'b1);
    repeat (40) @(negedge clk);
    check_q(phy.tx_q, exp_q);
    mode = 2'h0;
  endtask : t_tx

  task automatic t_fill;
    int cnt;
    cnt = 0;
    setup(16'h0001, 16'h0001);
    mode = 2'h2;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      if (tx_ready !== 1'b1) break;
      tx_beat  = mk(8'h60, i, 16, 1'b0);
      tx_valid = 1'b1;
      exp_q.push_back(tx_beat);
      cnt++;
    end
    tx_valid = 1'b0;
    check_val(cnt >= 8, 1'b1);
    mode = 2'h1;
    repeat (80) @(negedge clk);
    check_q(phy.tx_q, exp_q);
    mode = 2'h0;
  endtask : t_fill

  task automatic t_loop;
    setup(16'h0001, 16'h0011);
    send_tx(8'h70, 3, 1'b0, 1'b1);
    repeat (20) @(negedge clk);
    check_q(rx_q, exp_q);
    check_val(phy.tx_q.size(), 0);
    setup(16'h0001, 16'h0010);
    send_tx(8'h78, 3, 1'b0, 1'b0);
    repeat (20) @(negedge clk);
    check_val(rx_q.size() + phy.tx_q.size(), 0);
  endtask : t_loop

  task automatic t_rx;
    setup(16'h0001, 16'h0001);
    for (int i = 0; i < 4; i++) exp_q.push_back(mk(8'h80, i, 4, 1'b0));
    phy.send_frame(8'h80, 4, 1'b0);
    repeat (10) @(negedge clk);
    check_q(rx_q, exp_q);
    setup(16'h0001, 16'h0000);
    phy.send_frame(8'h88, 4, 1'b0);
    repeat (10) @(negedge clk);
    check_val(rx_q.size(), 0);
  endtask : t_rx

  task automatic t_pause;
    setup(16'h0001, 16'h0005);
    pause_cnt = 0;
    phy.send_frame(8'h90, 2, 1'b1);
    repeat (10) @(negedge clk);
    check_val(pause_cnt, 1);
    setup(16'h0001, 16'h0001);
    phy.send_frame(8'h94, 2, 1'b1);
    repeat (10) @(negedge clk);
    check_val(pause_cnt, 1);
    setup(16'h0000, 16'h0005);
    phy.send_frame(8'h98, 2, 1'b1);
    repeat (10) @(negedge clk);
    check_val(pause_cnt, 1);
  endtask : t_pause

  // Run needs about 12 us; over thirty times that before giving up
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst_n    = 1'b0;
    addr     = 8'h00;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    tx_beat  = '0;
    tx_valid = 1'b0;
    rx_ready = 1'b1;
    mode     = 2'h0;
    repeat (20) @(negedge clk);
    check_val(rnd, mcc_pkg::RNG_SEED);
    check_val(tx_ready, 1'b1);
    rst_n = 1'b1;
    t_regs();
    t_policy();
    t_rng();
    t_tx();
    t_fill();
    t_loop();
    t_rx();
    t_pause();
    tally_and_finish();
  end
endmodule : test_mac_control_config_regs

`default_nettype wire
